//--- hw/csw_pkg.sv
package csw_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_SCR_H_START_LOW  = 8'h38;
	localparam logic [7:0] IDX_SCR_H_START_HIGH = 8'h39;
	localparam logic [7:0] IDX_SCR_H_END_LOW    = 8'h3C;
	localparam logic [7:0] IDX_SCR_H_END_HIGH   = 8'h3D;
	localparam logic [7:0] IDX_SCR_V_END_LOW    = 8'h3E;
	localparam logic [7:0] IDX_SCR_V_END_HIGH   = 8'h3F;
	localparam logic [7:0] IDX_WR_CTRL_MAIN     = 8'h40;
	localparam logic [7:0] IDX_WR_CTRL_TARGET   = 8'h41;
	localparam logic [7:0] IDX_BLINK_PERIOD     = 8'h44;
	localparam logic [7:0] IDX_RD_SCAN_DIR      = 8'h45;
	localparam logic [7:0] IDX_WR_POS_X_LOW     = 8'h46;
	localparam logic [7:0] IDX_WR_POS_X_HIGH    = 8'h47;
	localparam logic [7:0] IDX_WR_POS_Y_LOW     = 8'h48;
	localparam logic [7:0] IDX_WR_POS_Y_HIGH    = 8'h49;
	localparam logic [7:0] IDX_RD_POS_X_LOW     = 8'h4A;
	localparam logic [7:0] IDX_RD_POS_X_HIGH    = 8'h4B;
	localparam logic [7:0] IDX_RD_POS_Y_LOW     = 8'h4C;
	localparam logic [7:0] IDX_RD_POS_Y_HIGH    = 8'h4D;
	localparam logic [7:0] IDX_CARET_WIDTH      = 8'h4E;
	localparam logic [7:0] IDX_CARET_HEIGHT     = 8'h4F;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int WCM_TEXT      = 7;
	localparam int WCM_SHOW      = 6;
	localparam int WCM_BLINK     = 5;
	localparam int WCM_WDIR_LSB  = 2;
	localparam int WCM_WR_NOINC  = 1;
	localparam int WCM_RD_NOINC  = 0;
	localparam int WCT_GC_EN     = 7;
	localparam int WCT_GC_SEL_LSB = 4;
	localparam int WCT_DEST_LSB  = 2;
	localparam int WCT_LAYER     = 0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_RST      = 8'h00;
	localparam logic [4:0] CARET_W_RST  = 5'h07;
	localparam logic [4:0] CARET_H_RST  = 5'h00;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DIR_LR_TD = 2'h0,
		DIR_RL_TD = 2'h1,
		DIR_TD_LR = 2'h2,
		DIR_DT_LR = 2'h3
	} csw_dir_t;

	typedef enum logic [1:0] {
		DEST_LAYERS = 2'h0,
		DEST_CHAR_RAM = 2'h1,
		DEST_GCURS  = 2'h2,
		DEST_PATTERN = 2'h3
	} csw_dest_t;

	typedef struct packed {
		logic [9:0] x;
		logic [8:0] y;
	} csw_pos_t;

endpackage

//--- hw/csw_regs.sv
`timescale 1ns/10ps
module csw_regs
	import csw_pkg::*;
#(
	parameter int         ADDR_W = 12,
	parameter logic [9:0] X_MAX  = 10'h31F,
	parameter logic [8:0] Y_MAX  = 9'h1DF
) (
	// Clock and reset
	input  wire logic              i_clock,
	input  wire logic              i_rst_n,
	// APB slave
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [ADDR_W-1:0] i_paddr,
	input  wire logic [31:0]       i_pwdata,
	input  wire logic [3:0]        i_pstrb,
	output logic                   o_pready,
	output logic [31:0]            o_prdata,
	output logic                   o_pslverr,
	// Memory access events and display context
	input  wire logic              i_mem_wr,
	input  wire logic              i_mem_rd,
	input  wire logic              i_frame_tick,
	input  wire logic              i_res_le_480x400,
	input  wire logic              i_depth_8bpp,
	input  wire logic [1:0]        i_font_scale_x,
	input  wire logic [1:0]        i_font_scale_y,
	// Settings towards the controller
	output logic                   o_text_mode,
	output logic                   o_caret_show,
	output csw_pos_t               o_wr_pos,
	output csw_pos_t               o_rd_pos,
	output logic                   o_gcursor_en,
	output logic [2:0]             o_gcursor_sel,
	output csw_dest_t              o_wr_dest,
	output logic                   o_wr_layer2,
	output logic [6:0]             o_caret_w_px,
	output logic [6:0]             o_caret_h_px,
	output logic [9:0]             o_scroll_h_start,
	output logic [9:0]             o_scroll_h_end,
	output logic [8:0]             o_scroll_v_end
);

	// ----------------------------------------------------------------
	// Bus state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		APB_IDLE = 2'b01,
		APB_ACK  = 2'b10
	} csw_apb_t;

	csw_apb_t    apb_reg;
	csw_apb_t    apb_next;
	logic [7:0]  idx;
	logic        addr_ok;
	logic        wr_en;
	logic [7:0]  wd;
	logic [7:0]  rd_byte;

	assign idx     = i_paddr[9:2];
	assign addr_ok = (i_paddr[1:0] == 2'h0) && (i_paddr[ADDR_W-1:10] == '0) && known(idx);
	assign wr_en   = (apb_reg == APB_ACK) && i_psel && i_penable && i_pwrite
	                 && addr_ok && i_pstrb[0];
	assign wd      = i_pwdata[7:0];
	assign apb_next = (apb_reg == APB_IDLE && i_psel && i_penable) ? APB_ACK : APB_IDLE;

	function automatic logic known(input logic [7:0] a);
		known = (a >= IDX_SCR_H_START_LOW && a <= IDX_SCR_H_START_HIGH)
		     || (a >= IDX_SCR_H_END_LOW && a <= IDX_WR_CTRL_TARGET)
		     || (a >= IDX_BLINK_PERIOD && a <= IDX_CARET_HEIGHT);
	endfunction

	function automatic logic hit(input logic [7:0] a);
		hit = wr_en && (idx == a);
	endfunction

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [9:0] h_start_reg;
	logic [9:0] h_end_reg;
	logic [8:0] v_end_reg;
	logic [7:0] wcm_reg;
	logic [7:0] wct_reg;
	logic [7:0] blink_period_reg;
	logic [1:0] rdir_reg;
	csw_pos_t   wpos_reg;
	csw_pos_t   wpos_next;
	csw_pos_t   rpos_reg;
	csw_pos_t   rpos_next;
	logic [4:0] caret_w_reg;
	logic [4:0] caret_h_reg;
	logic [7:0] blink_cnt_reg;
	logic [7:0] blink_cnt_next;
	logic       blink_phase_reg;
	logic       blink_phase_next;

	// ----------------------------------------------------------------
	// Cursor stepping
	// ----------------------------------------------------------------
	function automatic csw_pos_t step(input csw_pos_t p, input logic [1:0] dir,
	                                  input logic text);
		csw_pos_t   n;
		logic [1:0] d;
		n = p;
		d = text ? DIR_LR_TD : dir;
		unique case (d)
			DIR_LR_TD: begin
				if (p.x >= X_MAX) begin
					n.x = 10'h000;
					n.y = (p.y >= Y_MAX) ? 9'h000 : p.y + 9'h001;
				end else begin
					n.x = p.x + 10'h001;
				end
			end
			DIR_RL_TD: begin
				if (p.x == 10'h000) begin
					n.x = X_MAX;
					n.y = (p.y >= Y_MAX) ? 9'h000 : p.y + 9'h001;
				end else begin
					n.x = p.x - 10'h001;
				end
			end
			DIR_TD_LR: begin
				if (p.y >= Y_MAX) begin
					n.y = 9'h000;
					n.x = (p.x >= X_MAX) ? 10'h000 : p.x + 10'h001;
				end else begin
					n.y = p.y + 9'h001;
				end
			end
			DIR_DT_LR: begin
				if (p.y == 9'h000) begin
					n.y = Y_MAX;
					n.x = (p.x >= X_MAX) ? 10'h000 : p.x + 10'h001;
				end else begin
					n.y = p.y - 9'h001;
				end
			end
		endcase
		step = n;
	endfunction

	// Host write to a position byte wins over a same-cycle advance
	always_comb begin
		wpos_next = wpos_reg;
		if (i_mem_wr && !wcm_reg[WCM_WR_NOINC]) begin
			wpos_next = step(wpos_reg, wcm_reg[WCM_WDIR_LSB +: 2], wcm_reg[WCM_TEXT]);
		end
		if (hit(IDX_WR_POS_X_LOW)) begin
			wpos_next.x[7:0] = wd;
		end
		if (hit(IDX_WR_POS_X_HIGH)) begin
			wpos_next.x[9:8] = wd[1:0];
		end
		if (hit(IDX_WR_POS_Y_LOW)) begin
			wpos_next.y[7:0] = wd;
		end
		if (hit(IDX_WR_POS_Y_HIGH)) begin
			wpos_next.y[8] = wd[0];
		end
	end

	always_comb begin
		rpos_next = rpos_reg;
		if (i_mem_rd && !wcm_reg[WCM_RD_NOINC]) begin
			rpos_next = step(rpos_reg, rdir_reg, wcm_reg[WCM_TEXT]);
		end
		if (hit(IDX_RD_POS_X_LOW)) begin
			rpos_next.x[7:0] = wd;
		end
		if (hit(IDX_RD_POS_X_HIGH)) begin
			rpos_next.x[9:8] = wd[1:0];
		end
		if (hit(IDX_RD_POS_Y_LOW)) begin
			rpos_next.y[7:0] = wd;
		end
		if (hit(IDX_RD_POS_Y_HIGH)) begin
			rpos_next.y[8] = wd[0];
		end
	end

	// ----------------------------------------------------------------
	// Blink timing
	// ----------------------------------------------------------------
	logic blink_wrap;

	assign blink_wrap       = i_frame_tick && (blink_cnt_reg == blink_period_reg);
	assign blink_cnt_next   = blink_wrap ? 8'h00
	                        : (i_frame_tick ? blink_cnt_reg + 8'h01 : blink_cnt_reg);
	assign blink_phase_next = blink_wrap ? ~blink_phase_reg : blink_phase_reg;

	// ----------------------------------------------------------------
	// Read mux (reserved bits zero)
	// ----------------------------------------------------------------
	always_comb begin
		rd_byte = 8'h00;
		unique case (idx)
			IDX_SCR_H_START_LOW:  rd_byte = h_start_reg[7:0];
			IDX_SCR_H_START_HIGH: rd_byte = {6'h00, h_start_reg[9:8]};
			IDX_SCR_H_END_LOW:    rd_byte = h_end_reg[7:0];
			IDX_SCR_H_END_HIGH:   rd_byte = {6'h00, h_end_reg[9:8]};
			IDX_SCR_V_END_LOW:    rd_byte = v_end_reg[7:0];
			IDX_SCR_V_END_HIGH:   rd_byte = {7'h00, v_end_reg[8]};
			IDX_WR_CTRL_MAIN:     rd_byte = wcm_reg;
			IDX_WR_CTRL_TARGET:   rd_byte = wct_reg;
			IDX_BLINK_PERIOD:     rd_byte = blink_period_reg;
			IDX_RD_SCAN_DIR:      rd_byte = {6'h00, rdir_reg};
			IDX_WR_POS_X_LOW:     rd_byte = wpos_reg.x[7:0];
			IDX_WR_POS_X_HIGH:    rd_byte = {6'h00, wpos_reg.x[9:8]};
			IDX_WR_POS_Y_LOW:     rd_byte = wpos_reg.y[7:0];
			IDX_WR_POS_Y_HIGH:    rd_byte = {7'h00, wpos_reg.y[8]};
			IDX_RD_POS_X_LOW:     rd_byte = rpos_reg.x[7:0];
			IDX_RD_POS_X_HIGH:    rd_byte = {6'h00, rpos_reg.x[9:8]};
			IDX_RD_POS_Y_LOW:     rd_byte = rpos_reg.y[7:0];
			IDX_RD_POS_Y_HIGH:    rd_byte = {7'h00, rpos_reg.y[8]};
			IDX_CARET_WIDTH:      rd_byte = {3'h0, caret_w_reg};
			IDX_CARET_HEIGHT:     rd_byte = {3'h0, caret_h_reg};
			default:              rd_byte = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// Derived outputs
	// ----------------------------------------------------------------
	logic [2:0] fx;
	logic [2:0] fy;
	logic [6:0] w_px_next;
	logic [6:0] h_px_next;
	logic       show_next;
	logic       layer2_next;

	assign fx          = {1'b0, i_font_scale_x} + 3'h1;
	assign fy          = {1'b0, i_font_scale_y} + 3'h1;
	assign w_px_next   = {2'h0, caret_w_reg} * {4'h0, fx};
	assign h_px_next   = {2'h0, caret_h_reg} * {4'h0, fy};
	assign show_next   = wcm_reg[WCM_SHOW]
	                     && (!wcm_reg[WCM_BLINK] || blink_phase_reg);
	assign layer2_next = wct_reg[WCT_LAYER]
	                     && (i_res_le_480x400 || i_depth_8bpp);

	// ----------------------------------------------------------------
	// Bus registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			apb_reg   <= APB_IDLE;
			o_pready  <= 1'b0;
			o_prdata  <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else begin
			apb_reg   <= apb_next;
			o_pready  <= (apb_next == APB_ACK);
			o_prdata  <= (apb_next == APB_ACK && addr_ok) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			o_pslverr <= (apb_next == APB_ACK) && !addr_ok;
		end
	end

	// ----------------------------------------------------------------
	// Setting registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			h_start_reg      <= 10'h000;
			h_end_reg        <= 10'h000;
			v_end_reg        <= 9'h000;
			wcm_reg          <= REG_RST;
			wct_reg          <= REG_RST;
			blink_period_reg <= REG_RST;
			rdir_reg         <= 2'h0;
			caret_w_reg      <= CARET_W_RST;
			caret_h_reg      <= CARET_H_RST;
		end else begin
			if (hit(IDX_SCR_H_START_LOW)) begin
				h_start_reg[7:0] <= wd;
			end
			if (hit(IDX_SCR_H_START_HIGH)) begin
				h_start_reg[9:8] <= wd[1:0];
			end
			if (hit(IDX_SCR_H_END_LOW)) begin
				h_end_reg[7:0] <= wd;
			end
			if (hit(IDX_SCR_H_END_HIGH)) begin
				h_end_reg[9:8] <= wd[1:0];
			end
			if (hit(IDX_SCR_V_END_LOW)) begin
				v_end_reg[7:0] <= wd;
			end
			if (hit(IDX_SCR_V_END_HIGH)) begin
				v_end_reg[8] <= wd[0];
			end
			if (hit(IDX_WR_CTRL_MAIN)) begin
				wcm_reg <= wd & 8'hEF;
			end
			if (hit(IDX_WR_CTRL_TARGET)) begin
				wct_reg <= wd & 8'hFD;
			end
			if (hit(IDX_BLINK_PERIOD)) begin
				blink_period_reg <= wd;
			end
			if (hit(IDX_RD_SCAN_DIR)) begin
				rdir_reg <= wd[1:0];
			end
			if (hit(IDX_CARET_WIDTH)) begin
				caret_w_reg <= wd[4:0];
			end
			if (hit(IDX_CARET_HEIGHT)) begin
				caret_h_reg <= wd[4:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Cursors, blink and outputs
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			wpos_reg        <= '0;
			rpos_reg        <= '0;
			blink_cnt_reg   <= 8'h00;
			blink_phase_reg <= 1'b0;
		end else begin
			wpos_reg        <= wpos_next;
			rpos_reg        <= rpos_next;
			blink_cnt_reg   <= blink_cnt_next;
			blink_phase_reg <= blink_phase_next;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_text_mode      <= 1'b0;
			o_caret_show     <= 1'b0;
			o_wr_pos         <= '0;
			o_rd_pos         <= '0;
			o_gcursor_en     <= 1'b0;
			o_gcursor_sel    <= 3'h0;
			o_wr_dest        <= DEST_LAYERS;
			o_wr_layer2      <= 1'b0;
			o_caret_w_px     <= 7'h00;
			o_caret_h_px     <= 7'h00;
			o_scroll_h_start <= 10'h000;
			o_scroll_h_end   <= 10'h000;
			o_scroll_v_end   <= 9'h000;
		end else begin
			o_text_mode      <= wcm_reg[WCM_TEXT];
			o_caret_show     <= show_next;
			o_wr_pos         <= wpos_reg;
			o_rd_pos         <= rpos_reg;
			o_gcursor_en     <= wct_reg[WCT_GC_EN];
			o_gcursor_sel    <= wct_reg[WCT_GC_SEL_LSB +: 3];
			o_wr_dest        <= csw_dest_t'(wct_reg[WCT_DEST_LSB +: 2]);
			o_wr_layer2      <= layer2_next;
			o_caret_w_px     <= w_px_next;
			o_caret_h_px     <= h_px_next;
			o_scroll_h_start <= h_start_reg;
			o_scroll_h_end   <= h_end_reg;
			o_scroll_v_end   <= v_end_reg;
		end
	end

endmodule

//--- bench/csw_regs_chk.sv
`timescale 1ns/10ps
module csw_regs_chk
	import csw_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input logic              i_clock,
	input logic              i_rst_n,
	// Bus
	input logic              i_psel,
	input logic              i_penable,
	input logic              i_pwrite,
	input logic [ADDR_W-1:0] i_paddr,
	input logic              o_pready,
	input logic [31:0]       o_prdata,
	input logic              o_pslverr,
	// Events and context
	input logic              i_mem_wr,
	input logic              i_mem_rd,
	input logic              i_res_le_480x400,
	input logic              i_depth_8bpp,
	input logic [1:0]        i_font_scale_x,
	// Settings
	input csw_pos_t          o_wr_pos,
	input csw_pos_t          o_rd_pos,
	input logic              o_wr_layer2,
	input logic [6:0]        o_caret_w_px,
	input logic [9:0]        o_scroll_h_end,
	input logic [8:0]        o_scroll_v_end
);
	// ----
	// Bus phases
	// ----
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	wire bus_wr = i_psel && i_penable && i_pwrite;
	sequence s_setup;
		i_psel && !i_penable;
	endsequence
	sequence s_access;
		s_setup ##1 (i_psel && i_penable);
	endsequence
	a_ready_one_wait: assert property (s_access |=> o_pready)
		else $error("ready not one cycle after access");
	a_ready_pulse: assert property (o_pready |=> !o_pready)
		else $error("ready held too long");
	a_err_misalign: assert property (
		s_setup ##1 (i_psel && i_penable && i_paddr[1:0] != 2'h0) |=>
		o_pslverr && o_prdata == 32'h0) else $error("misaligned access not refused");
	a_upper_zero: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_scroll_hold: assert property (!bus_wr && !$past(bus_wr) |=>
		$stable(o_scroll_h_end) &&
		$stable(o_scroll_v_end)) else $error("scroll end moved without write");
	a_wr_pos_hold: assert property (!i_mem_wr && !$past(i_mem_wr) && !bus_wr &&
		!$past(bus_wr) |=> $stable(o_wr_pos))
		else $error("write cursor moved without cause");
	a_rd_pos_hold: assert property (!i_mem_rd && !$past(i_mem_rd) && !bus_wr &&
		!$past(bus_wr) |=> $stable(o_rd_pos))
		else $error("read cursor moved without cause");
	a_layer_gate: assert property (
		o_wr_layer2 |-> $past(i_res_le_480x400 || i_depth_8bpp))
		else $error("layer two chosen while not allowed");
	a_caret_scale: assert property (
		o_caret_w_px % ({5'h00, $past(i_font_scale_x)} + 7'h01) == 7'h00)
		else $error("caret width not scaled");
endmodule

bind csw_regs csw_regs_chk #(.ADDR_W(ADDR_W)) csw_regs_chk_i (
	.i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_pready(o_pready), .o_prdata(o_prdata),
	.o_pslverr(o_pslverr), .i_mem_wr(i_mem_wr), .i_mem_rd(i_mem_rd),
	.i_res_le_480x400(i_res_le_480x400), .i_depth_8bpp(i_depth_8bpp),
	.i_font_scale_x(i_font_scale_x), .o_wr_pos(o_wr_pos), .o_rd_pos(o_rd_pos),
	.o_wr_layer2(o_wr_layer2), .o_caret_w_px(o_caret_w_px),
	.o_scroll_h_end(o_scroll_h_end), .o_scroll_v_end(o_scroll_v_end)
);

//--- bench/csw_host.sv
`timescale 1ns/10ps
module csw_host (
	// Clock
	input  logic        i_clock,
	// Bus master
	output logic        o_psel,
	output logic        o_penable,
	output logic        o_pwrite,
	output logic [11:0] o_paddr,
	output logic [31:0] o_pwdata,
	output logic [3:0]  o_pstrb,
	input  logic        i_pready,
	input  logic [31:0] i_prdata,
	input  logic        i_pslverr
);
	// ----
	// One transfer, setup then access until ready
	// ----
	// Font source bit lives outside this block and is never set here
	// Buffer scroll is never used, so text mode may be chosen freely
	initial begin
		{o_psel, o_penable, o_pwrite, o_pstrb} = 7'h00;
		o_paddr = 12'h000;
		o_pwdata = 32'h0;
	end
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
			input logic [3:0] s, output logic [31:0] r, output logic e, output logic h);
		int n;
		@(posedge i_clock);
		o_psel <= 1'b1;
		o_penable <= 1'b0;
		o_pwrite <= w;
		o_paddr <= a;
		o_pwdata <= d;
		o_pstrb <= s;
		@(posedge i_clock);
		o_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clock);
			n++;
		end while (i_pready !== 1'b1 && n < 16);
		h = (i_pready !== 1'b1);
		r = i_prdata;
		e = i_pslverr;
		o_psel <= 1'b0;
		o_penable <= 1'b0;
		o_paddr <= ~a;
		o_pwdata <= ~d;
	endtask
endmodule

//--- bench/csw_regs_tb.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
	$display("mismatch %s exp %0h got %0h", nm, ex, got); num_errors++; end end
module csw_regs_tb
	import csw_pkg::*;
;
	localparam logic [9:0] XM = 10'h31F;
	localparam logic [8:0] YM = 9'h1DF;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	logic        mem_wr, mem_rd, frame, res_le, d8, text, show, gc_en, layer2;
	logic [1:0]  sx, sy;
	logic [2:0]  gc_sel;
	csw_dest_t   dest;
	csw_pos_t    wpos, rpos;
	logic [6:0]  cw, ch;
	logic [9:0]  hs, he;
	logic [8:0]  ve;
	int          num_errors, cmp_count;
	logic [7:0]  ids [20] = '{8'h38, 8'h39, 8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h40, 8'h41,
		8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4A, 8'h4B, 8'h4C, 8'h4D, 8'h4E, 8'h4F};
	logic [7:0]  msk [20] = '{8'hFF, 8'h03, 8'hFF, 8'h03, 8'hFF, 8'h01, 8'hEF, 8'hFD,
		8'hFF, 8'h03, 8'hFF, 8'h03, 8'hFF, 8'h01, 8'hFF, 8'h03, 8'hFF, 8'h01, 8'h1F, 8'h1F};
	csw_pos_t    sp [4] = '{'{XM, 9'h005}, '{10'h000, 9'h005}, '{10'h005, YM}, '{10'h005, 9'h000}};
	csw_pos_t    ep [4] = '{'{10'h000, 9'h006}, '{XM, 9'h006}, '{10'h006, 9'h000}, '{10'h006, YM}};
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	csw_regs #(.X_MAX(XM), .Y_MAX(YM)) csw_regs_i (
		.i_clock(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
		.o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_mem_wr(mem_wr),
		.i_mem_rd(mem_rd), .i_frame_tick(frame), .i_res_le_480x400(res_le),
		.i_depth_8bpp(d8), .i_font_scale_x(sx), .i_font_scale_y(sy), .o_text_mode(text),
		.o_caret_show(show), .o_wr_pos(wpos), .o_rd_pos(rpos), .o_gcursor_en(gc_en),
		.o_gcursor_sel(gc_sel), .o_wr_dest(dest), .o_wr_layer2(layer2), .o_caret_w_px(cw),
		.o_caret_h_px(ch), .o_scroll_h_start(hs), .o_scroll_h_end(he), .o_scroll_v_end(ve)
	);
	csw_host csw_host_i (
		.i_clock(clk), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
		.o_paddr(paddr), .o_pwdata(pwdata), .o_pstrb(pstrb), .i_pready(pready),
		.i_prdata(prdata), .i_pslverr(pslverr)
	);
	// ----
	// Tasks
	// ----
	task automatic summarize();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
			input logic [3:0] s, output logic [7:0] r, output logic e);
		logic [31:0] rd;
		logic        h;
		csw_host_i.xfer(w, a, {24'h000000, d}, s, rd, e, h);
		r = rd[7:0];
		if (h) begin
			$display("mismatch pready exp 1 got 0");
			num_errors++;
			summarize();
		end
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		logic [7:0] r;
		logic       e;
		bus(1'b1, {2'h0, i, 2'h0}, d, 4'hF, r, e);
		repeat (2) @(posedge clk);
	endtask
	task automatic rdc(input logic [7:0] i, input logic [7:0] x);
		logic [7:0] r;
		logic       e;
		bus(1'b0, {2'h0, i, 2'h0}, 8'h00, 4'hF, r, e);
		`CHK("reg", x, r)
	endtask
	task automatic tick(input logic [2:0] k);
		@(posedge clk);
		{mem_wr, mem_rd, frame} <= k;
		@(posedge clk);
		{mem_wr, mem_rd, frame} <= 3'h0;
		repeat (2) @(posedge clk);
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_regs();
		for (int n = 0; n < 20; n++) begin
			rdc(ids[n], (ids[n] == IDX_CARET_WIDTH) ? 8'h07 : 8'h00);
		end
		`CHK("caret_w", 7'h07, cw)
	endtask
	task automatic t_mask();
		for (int n = 0; n < 20; n++) begin
			wr(ids[n], 8'hFF);
			rdc(ids[n], msk[n]);
		end
		`CHK("h_end", 10'h3FF, he)
		`CHK("v_end", 9'h1FF, ve)
		`CHK("h_start", 10'h3FF, hs)
		`CHK("wpos", 19'h7FFFF, wpos)
		`CHK("rpos", 19'h7FFFF, rpos)
		for (int n = 0; n < 20; n++) begin
			wr(ids[n], 8'h00);
		end
	endtask
	task automatic t_bad();
		logic [7:0] r;
		logic       e;
		wr(IDX_WR_POS_X_LOW, 8'h3C);
		bus(1'b0, 12'h108, 8'h00, 4'hF, r, e);
		`CHK("err_unmapped", 1'b1, e)
		`CHK("rd_unmapped", 8'h00, r)
		bus(1'b1, 12'h119, 8'hA5, 4'hF, r, e);
		`CHK("err_misalign", 1'b1, e)
		bus(1'b1, 12'h518, 8'hA5, 4'hF, r, e);
		`CHK("err_high", 1'b1, e)
		bus(1'b1, 12'h118, 8'hA5, 4'hE, r, e);
		`CHK("err_strb", 1'b0, e)
		rdc(IDX_WR_POS_X_LOW, 8'h3C);
	endtask
	task automatic t_fields();
		for (int n = 0; n < 8; n++) begin
			wr(IDX_WR_CTRL_TARGET, {n[0], n[2:0], n[1:0], 2'h0});
			`CHK("gc_en", n[0], gc_en)
			`CHK("gc_sel", n[2:0], gc_sel)
			`CHK("dest", n[1:0], dest)
		end
		for (int n = 0; n < 4; n++) begin
			res_le <= n[1];
			d8 <= n[0];
			wr(IDX_WR_CTRL_TARGET, 8'h01);
			`CHK("layer2", n[1] | n[0], layer2)
		end
	endtask
	task automatic step(input logic rs, input logic [7:0] c, input csw_pos_t p,
			input csw_pos_t q);
		logic [7:0] b;
		b = rs ? IDX_RD_POS_X_LOW : IDX_WR_POS_X_LOW;
		wr(IDX_WR_CTRL_MAIN, c);
		wr(IDX_RD_SCAN_DIR, {6'h00, c[3:2]});
		wr(b, p.x[7:0]);
		wr(b + 8'h01, {6'h00, p.x[9:8]});
		wr(b + 8'h02, p.y[7:0]);
		wr(b + 8'h03, {7'h00, p.y[8]});
		tick(rs ? 3'h2 : 3'h4);
		rdc(b, q.x[7:0]);
		rdc(b + 8'h01, {6'h00, q.x[9:8]});
		rdc(b + 8'h02, q.y[7:0]);
		rdc(b + 8'h03, {7'h00, q.y[8]});
		`CHK("pos", q, rs ? rpos : wpos)
		`CHK("text", c[7], text)
	endtask
	task automatic t_blink();
		wr(IDX_BLINK_PERIOD, 8'h02);
		wr(IDX_WR_CTRL_MAIN, 8'h60);
		repeat (2) tick(3'h1);
		`CHK("show_early", 1'b0, show)
		tick(3'h1);
		`CHK("show_toggle", 1'b1, show)
		wr(IDX_WR_CTRL_MAIN, 8'h20);
		`CHK("show_hidden", 1'b0, show)
		wr(IDX_WR_CTRL_MAIN, 8'h40);
		repeat (3) tick(3'h1);
		`CHK("show_steady", 1'b1, show)
		wr(IDX_WR_CTRL_MAIN, 8'h60);
		`CHK("show_phase", 1'b0, show)
	endtask
	initial begin
		rst_n = 1'b0;
		{mem_wr, mem_rd, frame, res_le, d8, sx, sy} = 9'h000;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_mask();
		t_bad();
		t_fields();
		for (int d = 0; d < 4; d++) begin
			step(1'b0, {4'h0, d[1:0], 2'h0}, sp[d], ep[d]);
			step(1'b1, {4'h0, d[1:0], 2'h0}, sp[d], ep[d]);
		end
		step(1'b0, 8'h84, '{10'h00A, 9'h005}, '{10'h00B, 9'h005});
		step(1'b0, 8'h02, '{10'h00A, 9'h005}, '{10'h00A, 9'h005});
		step(1'b1, 8'h01, '{10'h00A, 9'h005}, '{10'h00A, 9'h005});
		t_blink();
		sx <= 2'h2;
		sy <= 2'h3;
		wr(IDX_CARET_WIDTH, 8'h05);
		wr(IDX_CARET_HEIGHT, 8'h03);
		`CHK("caret_w", 7'h0F, cw)
		`CHK("caret_h", 7'h0C, ch)
		sx <= 2'h0;
		sy <= 2'h0;
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		summarize();
	end
endmodule
